/* verilog/synth_cfg_pkg.sv */
package synth_cfg_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [6:0] IDX_PUMP = 7'h2a;
  localparam logic [6:0] IDX_RAND = 7'h2f;
  localparam logic [6:0] IDX_TUNE_C = 7'h35;
  localparam logic [6:0] IDX_TUNE_B = 7'h3a;
  localparam logic [6:0] IDX_TUNE_A = 7'h3c;
  localparam logic [6:0] IDX_CTRL = 7'h00;
  localparam logic [6:0] IDX_UP = 7'h29;
  localparam logic [6:0] IDX_TOTAL = 7'h01;
  // Reset values
  localparam logic [15:0] RST_PUMP = 16'h0210;
  localparam logic [15:0] RST_RAND = 16'h0000;
  localparam logic [15:0] RST_TUNE_C = 16'h2802;
  localparam logic [15:0] RST_TUNE_B = 16'h0c00;
  localparam logic [15:0] RST_TUNE_A = 16'h4000;
  localparam logic [4:0] RST_UP = 5'h10;
  // Field positions
  localparam int POL_BIT = 5;
  localparam int DN_LSB = 0;
  localparam int RAND_LSB = 13;
  localparam int UP_LSB = 7;
  localparam int RESET_BIT = 1;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    RAND_OFF = 2'b00,
    RAND_WEAK = 2'b01,
    RAND_MEDIUM = 2'b10,
    RAND_STRONG = 2'b11
  } rand_level_e;
endpackage

/* verilog/synth_config_registers.sv */
`timescale 1ns/100ps
// How it works
// RULE1: Power-up and the reset control bit load every register's reset value.
// RULE2: Reset values are not a working setup; software writes all registers.
// RULE3: Tuning register 3Ch resets to 4000h; software writes A000h.
// RULE4: Tuning register 3Ah resets to C00h; software writes 8C00h.
// RULE5: Tuning register 35h resets to 2802h; software writes 7806h.
// RULE6: Bits 14:13 of 2Fh pick randomization level, reset zero.
// RULE7: Software writes zero to bit 15 and bits 12:0 of 2Fh.
// RULE8: Software writes 8h to bits 15:6 of 2Ah, which reset 8h.
// RULE9: Bit 5 of 2Ah picks pump polarity, 0 positive, reset zero.
// RULE10: Bits 4:0 of 2Ah set down current; 0 tri-states, reset 10h.
// RULE11: Software programs only even current codes.
// RULE12: Software keeps down code equal to the up code.
// RULE13: Total pump current code is down code plus up code.
// RULE14: Register 2Ah resets to 210h.
module synth_config_registers
  import synth_cfg_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [8:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [8:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Synthesizer controls
  output logic [1:0] rand_level,
  output logic ext_osc_pump_polarity,
  output logic [4:0] ext_osc_pump_down_current,
  output logic [4:0] ext_osc_pump_up_current,
  output logic [5:0] ext_osc_pump_total,
  output logic ext_osc_pump_tristate,
  output logic [15:0] tune_a,
  output logic [15:0] tune_b,
  output logic [15:0] tune_c
);

  logic [15:0] pump_polarity_current_r;
  logic [15:0] modulator_randomization_ctrl_r;
  logic [15:0] fixed_tuning_c_r;
  logic [15:0] fixed_tuning_b_r;
  logic [15:0] fixed_tuning_a_r;
  logic [4:0] up_current_r;
  logic soft_reset_r;
  logic [8:0] awaddr_r;
  logic aw_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_held_r;
  logic do_write;
  logic ctrl_hit;
  logic [6:0] widx;
  logic [6:0] ridx;
  wire logic [15:0] wval;
  logic [15:0] wold;
  logic wmapped;
  logic [31:0] rval;
  logic rmapped;

  // Write channel capture, address and data in either order
  // A half that arrives first is held until its partner is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 9'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end
    else if (do_write)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  // Waits for bvalid to clear so a new write cannot overrun the response
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign widx = awaddr_r[8:2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      // Each ready only while its own half is not held and no response waits, one write at a time
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready)
        && !s_axi_bvalid;
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready)
        && !s_axi_bvalid;
    end
  end

  // Current contents of the addressed register, merged per byte lane below
  always_comb
  begin
    wold = 16'h0000;
    case (widx)
      IDX_PUMP: wold = pump_polarity_current_r;
      IDX_RAND: wold = modulator_randomization_ctrl_r;
      IDX_TUNE_C: wold = fixed_tuning_c_r;
      IDX_TUNE_B: wold = fixed_tuning_b_r;
      IDX_TUNE_A: wold = fixed_tuning_a_r;
      IDX_UP: wold = {11'h000, up_current_r} << UP_LSB;
      default: wold = 16'h0000;
    endcase
  end

  // Strobes 2 and 3 have no storage behind them and are ignored
  genvar g;
  for (g = 0; g < 2; g = g + 1)
  begin : g_lane
    assign wval[8*g +: 8] = wstrb_r[g] ? wdata_r[8*g +: 8]
      : wold[8*g +: 8];
  end

  always_comb
  begin
    case (widx)
      IDX_PUMP, IDX_RAND, IDX_TUNE_C, IDX_TUNE_B, IDX_TUNE_A, IDX_UP,
      IDX_CTRL, IDX_TOTAL: wmapped = 1'b1;
      default: wmapped = 1'b0;
    endcase
  end

  // Only the reset bit of the control word does anything; others read zero
  assign ctrl_hit = do_write && widx == IDX_CTRL && wstrb_r[0]
    && wdata_r[RESET_BIT];

  // Reset control bit: self-clearing, acts on the cycle after the write
  // Bus state is left alone so the control write still gets its response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      soft_reset_r <= 1'b0;
    else
      soft_reset_r <= ctrl_hit;
  end

  // Configuration registers; software's values are stored as written
  // Soft reset outranks a write landing in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn || soft_reset_r) // RULE1
    begin
      pump_polarity_current_r <= RST_PUMP; // RULE14
      modulator_randomization_ctrl_r <= RST_RAND; // RULE6
      fixed_tuning_c_r <= RST_TUNE_C;
      fixed_tuning_b_r <= RST_TUNE_B;
      fixed_tuning_a_r <= RST_TUNE_A;
      up_current_r <= RST_UP;
    end
    else if (do_write)
    begin
      case (widx)
        IDX_PUMP: pump_polarity_current_r <= wval;
        IDX_RAND: modulator_randomization_ctrl_r <= wval;
        IDX_TUNE_C: fixed_tuning_c_r <= wval;
        IDX_TUNE_B: fixed_tuning_b_r <= wval;
        IDX_TUNE_A: fixed_tuning_a_r <= wval;
        IDX_UP: up_current_r <= wval[UP_LSB +: 5];
        default: up_current_r <= up_current_r;
      endcase
    end
  end

  // Write response
  // Writes to the read-only total are answered OKAY and dropped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wmapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read path
  // Live address is decoded; only its value at the handshake matters
  assign ridx = s_axi_araddr[8:2];

  always_comb
  begin
    rmapped = 1'b1;
    rval = 32'h00000000;
    case (ridx)
      IDX_PUMP: rval = {16'h0000, pump_polarity_current_r};
      IDX_RAND: rval = {16'h0000, modulator_randomization_ctrl_r};
      IDX_TUNE_C: rval = {16'h0000, fixed_tuning_c_r};
      IDX_TUNE_B: rval = {16'h0000, fixed_tuning_b_r};
      IDX_TUNE_A: rval = {16'h0000, fixed_tuning_a_r};
      IDX_UP: rval = {20'h00000, up_current_r, 7'h00};
      IDX_CTRL: rval = 32'h00000000;
      IDX_TOTAL: rval = {26'h0000000, ext_osc_pump_total};
      default: rmapped = 1'b0;
    endcase
  end

  // Address is refused while data waits, so arready returns a cycle late
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rval;
      s_axi_rresp <= rmapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
      s_axi_arready <= 1'b1;
  end

  // Field outputs, registered
  // One cycle behind the registers so every output is a flip-flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rand_level <= RAND_OFF;
      ext_osc_pump_polarity <= 1'b0;
      ext_osc_pump_down_current <= RST_PUMP[DN_LSB +: 5];
      ext_osc_pump_up_current <= RST_UP;
      ext_osc_pump_total <= {1'b0, RST_UP} + {1'b0, RST_PUMP[4:0]};
      ext_osc_pump_tristate <= 1'b0;
      tune_a <= RST_TUNE_A;
      tune_b <= RST_TUNE_B;
      tune_c <= RST_TUNE_C;
    end
    else
    begin
      rand_level <= modulator_randomization_ctrl_r[RAND_LSB +: 2]; // RULE6
      ext_osc_pump_polarity <= pump_polarity_current_r[POL_BIT]; // RULE9
      ext_osc_pump_down_current <=
        pump_polarity_current_r[DN_LSB +: 5]; // RULE10
      ext_osc_pump_up_current <= up_current_r;
      // Both codes are summed as-is; odd or mismatched codes pass through
      ext_osc_pump_total <= {1'b0, up_current_r}
        + {1'b0, pump_polarity_current_r[DN_LSB +: 5]}; // RULE13
      ext_osc_pump_tristate <=
        pump_polarity_current_r[DN_LSB +: 5] == 5'h00; // RULE10
      tune_a <= fixed_tuning_a_r;
      tune_b <= fixed_tuning_b_r;
      tune_c <= fixed_tuning_c_r;
    end
  end

endmodule

/* tb/synth_cfg_assertions.sv */
`timescale 1ns/100ps
module synth_cfg_assertions (
  // Clock, reset and bus handshakes
  input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready,
  input wire logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [31:0] s_axi_rdata,
  // Field outputs
  input wire logic [1:0] rand_level,
  input wire logic ext_osc_pump_polarity, ext_osc_pump_tristate,
  input wire logic [4:0] ext_osc_pump_down_current, ext_osc_pump_up_current,
  input wire logic [5:0] ext_osc_pump_total,
  input wire logic [15:0] tune_a, tune_b, tune_c
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rst_fields;
    tune_a == 16'h4000 && tune_b == 16'h0c00 && tune_c == 16'h2802 &&
    rand_level == 2'h0 && !ext_osc_pump_polarity &&
    ext_osc_pump_down_current == 5'h10 && ext_osc_pump_up_current == 5'h10;
  endsequence
  rst_values_a: assert property ($rose(aresetn) |-> rst_fields)
    else $error("fields not at reset values");
  pump_total_a: assert property (
    $stable(ext_osc_pump_down_current) && $stable(ext_osc_pump_up_current)
    |-> ext_osc_pump_total ==
    ext_osc_pump_down_current + ext_osc_pump_up_current)
    else $error("pump total is not the code sum");
  pump_tristate_a: assert property (ext_osc_pump_tristate ==
    (ext_osc_pump_down_current == 5'h0)) else $error("tristate wrong");
  wr_resp_a: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  aw_block_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
endmodule
bind synth_config_registers synth_cfg_assertions u_chk (.*);

/* tb/tb_synth_config_registers.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb_synth_config_registers;
  import synth_cfg_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [8:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [3:0] wr_strb = 4'h3;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ext_osc_pump_polarity, ext_osc_pump_tristate;
  logic [1:0] s_axi_bresp, s_axi_rresp, rand_level;
  logic [4:0] ext_osc_pump_down_current, ext_osc_pump_up_current;
  logic [5:0] ext_osc_pump_total;
  logic [15:0] tune_a, tune_b, tune_c;
  int n_fail = 0, tests_run = 0, cyc = 0;
  synth_config_registers dut (.*);
  initial forever #4 aclk = ~aclk;
  task automatic stop_test;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      stop_test;
    end
  end
  // Ready raised late so the slave must hold its answer
  task automatic wr(input logic [6:0] i, input logic [15:0] d,
    input logic [1:0] e);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {16'h0, d};
    s_axi_wstrb <= wr_strb;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1;
    @(posedge aclk);
    `CHK(s_axi_bresp, e)
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [6:0] i, input logic [15:0] d,
    input logic [1:0] e);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1;
    @(posedge aclk);
    `CHK(s_axi_rdata, {16'h0, d})
    `CHK(s_axi_rresp, e)
    s_axi_rready <= 0;
  endtask
  task automatic t_reset;
    rd(IDX_TUNE_A, 16'h4000, RESP_OKAY);
    rd(IDX_TUNE_B, 16'h0c00, RESP_OKAY);
    rd(IDX_TUNE_C, 16'h2802, RESP_OKAY);
    rd(IDX_RAND, 16'h0000, RESP_OKAY);
    rd(IDX_PUMP, 16'h0210, RESP_OKAY);
    `CHK({ext_osc_pump_tristate, ext_osc_pump_total}, 7'h20)
    $display("reset test done");
  endtask
  task automatic t_tune;
    wr(IDX_TUNE_A, 16'ha000, RESP_OKAY);
    wr(IDX_TUNE_B, 16'h8c00, RESP_OKAY);
    wr(IDX_TUNE_C, 16'h7806, RESP_OKAY);
    `CHK({tune_a, tune_b, tune_c}, 48'ha0008c007806)
    rd(IDX_TUNE_B, 16'h8c00, RESP_OKAY);
    for (int l = 0; l < 4; l++)
    begin
      wr(IDX_RAND, 16'(l) << 13, RESP_OKAY);
      `CHK(rand_level, 2'(l))
    end
    $display("tune test done");
  endtask
  task automatic t_pump;
    wr(IDX_PUMP, 16'h0220, RESP_OKAY);
    `CHK({ext_osc_pump_polarity, ext_osc_pump_tristate}, 2'h3)
    `CHK(ext_osc_pump_total, 6'h10)
    wr(IDX_PUMP, 16'h021e, RESP_OKAY);
    `CHK({ext_osc_pump_polarity, ext_osc_pump_down_current}, 6'h1e)
    wr(IDX_UP, 16'h0f00, RESP_OKAY);
    rd(IDX_TOTAL, 16'h003c, RESP_OKAY);
    rd(IDX_PUMP, 16'h021e, RESP_OKAY);
    wr(7'h10, 16'h1234, RESP_SLVERR);
    rd(7'h10, 16'h0000, RESP_SLVERR);
    $display("pump test done");
  endtask
  task automatic t_soft;
    wr(IDX_CTRL, 16'h0002, RESP_OKAY);
    repeat (3) @(posedge aclk);
    rd(IDX_TUNE_A, 16'h4000, RESP_OKAY);
    rd(IDX_PUMP, 16'h0210, RESP_OKAY);
    `CHK({ext_osc_pump_up_current, ext_osc_pump_total}, 11'h420)
    // Split-lane writes: each strobe moves only its own byte
    wr_strb = 4'h2;
    wr(IDX_TUNE_C, 16'h78aa, RESP_OKAY);
    rd(IDX_TUNE_C, 16'h7802, RESP_OKAY);
    wr_strb = 4'h1;
    wr(IDX_TUNE_C, 16'hbb06, RESP_OKAY);
    wr_strb = 4'h3;
    `CHK(tune_c, 16'h7806)
    $display("soft reset test done");
  endtask
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset;
    t_tune;
    t_pump;
    t_soft;
    stop_test;
  end
endmodule
